// *** hw/flash_protection_map_pkg.sv ***
package flash_protection_map_pkg;

   // ****************************************************************
   // Bus geometry
   // ****************************************************************
   localparam int ADR_W = 8;
   localparam int DAT_W = 32;
   localparam int SECTIONS = 5;

   // ****************************************************************
   // Register offsets (byte addresses)
   // ****************************************************************
   localparam logic [7:0] OFS_CTRL = 8'h00;
   localparam logic [7:0] OFS_SELECT = 8'h04;
   localparam logic [7:0] OFS_ENTRY = 8'h08;
   localparam logic [7:0] OFS_POS = 8'h0c;
   localparam logic [7:0] OFS_STATUS = 8'h10;
   localparam logic [7:0] OFS_BLOCKS = 8'h14;
   localparam logic [7:0] OFS_BASE = 8'h18;

   // ****************************************************************
   // Field positions
   // ****************************************************************
   localparam int CTRL_DENS_LSB = 0;
   localparam int CTRL_DENS_W = 4;
   localparam int SELECT_W = 3;
   localparam int ENTRY_TYPE_LSB = 0;
   localparam int ENTRY_COUNT_LSB = 8;
   localparam int ENTRY_START_LSB = 16;
   localparam int ENTRY_END_LSB = 24;
   localparam int POS_W = 10;
   localparam int POS_START_LSB = 0;
   localparam int POS_END_LSB = 16;
   localparam int POS_VALID_BIT = 31;
   localparam int STAT_ALL_OK_BIT = 0;
   localparam int STAT_REFUSED_BIT = 1;
   localparam int STAT_SEL_OK_BIT = 2;
   localparam int BASE_W = 24;

   // ****************************************************************
   // Reset values and density limits
   // ****************************************************************
   localparam logic [3:0] DENS_RESET = 4'h6;
   localparam logic [3:0] DENS_MIN = 4'h4;
   localparam logic [3:0] DENS_MAX = 4'h8;
   localparam logic [2:0] SELECT_RESET = 3'h0;

   // ****************************************************************
   // Sector types and the five major sections, bottom to top
   // ****************************************************************
   localparam logic [7:0] TYPE_MIN = 8'h01;
   localparam logic [7:0] TYPE_SMALL = 8'h02;
   localparam logic [7:0] TYPE_MID = 8'h03;
   localparam logic [7:0] TYPE_LARGE = 8'h04;
   localparam logic [23:0] SIZE_SMALL = 24'h002000;
   localparam logic [23:0] SIZE_MID = 24'h008000;
   localparam logic [23:0] SIZE_LARGE = 24'h010000;
   localparam logic [7:0] START_LITERAL_ZERO = 8'h00;

   localparam logic [SECTIONS-1:0][7:0] SECT_TYPE = {8'h02, 8'h03, 8'h04, 8'h03, 8'h02};
   // The large-block count byte is replaced by the density at run time.
   localparam logic [SECTIONS-1:0][7:0] SECT_COUNT = {8'h02, 8'h00, 8'h00, 8'h00, 8'h02};
   localparam logic [SECTIONS-1:0][7:0] SECT_START = {8'h07, 8'hfe, 8'h00, 8'hfd, 8'hff};
   localparam logic [SECTIONS-1:0][7:0] SECT_END = {8'h0e, 8'hfe, 8'hfc, 8'hfd, 8'h06};

endpackage

// *** hw/protect_loc_decode.sv ***
`timescale 1ns/1ps
`default_nettype none
module protect_loc_decode (
   input wire logic [7:0] adder,
   input wire logic [3:0] density,
   input wire logic is_start,
   output logic [flash_protection_map_pkg::POS_W-1:0] pos,
   output logic below_zero
);
   import flash_protection_map_pkg::*;

   logic literal_zero;
   logic signed [POS_W:0] sum;

   // A zero start byte names bit zero itself; every other byte is a signed adder.
   assign literal_zero = is_start && (adder == START_LITERAL_ZERO);
   // The adder is sign-extended before it meets the density term.
   assign sum = $signed((POS_W+1)'(1) << density) + $signed((POS_W+1)'(1))
                + $signed({{(POS_W-7){adder[7]}}, adder});
   assign pos = literal_zero ? '0 : sum[POS_W-1:0];
   assign below_zero = !literal_zero && sum[POS_W];
endmodule
`default_nettype wire

// *** hw/flash_protection_map_decoder.sv ***
// Functional notes
// - Section entry holds type, count, start, end.
// - Type codes 01H..04H select size definitions.
// - Start byte 00H means protection bit zero.
// - Nonzero start byte is adder to 2^m+1.
// - End byte is always adder to 2^m+1.
// - Protection bits step by one per block, by two per small block.
// - Bit span equals reported block count, twice it for small blocks.
// - Uniform small sectors are not described.
// - Type codes match basic table size entries.
// - Reappearing size gets its own section entry.
// - Layout 4x8K, 32K, 64K run, 32K, 4x8K.
// - Sections one to five in ascending address.
// - Density m is 4..8; reset uses 6.
// - Adders are signed 8-bit two's complement.
// - Large count 2^m-2; smaller counts 2^n.
// - Small blocks use read/write lock bit pairs.
//
// Chosen here: the Wishbone register port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module flash_protection_map_decoder #(
   parameter logic [3:0] DENS_DEFAULT = flash_protection_map_pkg::DENS_RESET
) (
   input wire logic MCLK,
   input wire logic RST_N,
   input wire logic CE,
   input wire logic WB_CYC_I,
   input wire logic WB_STB_I,
   input wire logic WB_WE_I,
   input wire logic [flash_protection_map_pkg::ADR_W-1:0] WB_ADR_I,
   input wire logic [3:0] WB_SEL_I,
   input wire logic [flash_protection_map_pkg::DAT_W-1:0] WB_DAT_I,
   output logic [flash_protection_map_pkg::DAT_W-1:0] WB_DAT_O,
   output logic WB_ACK_O
);
   import flash_protection_map_pkg::*;

   // ****************************************************************
   // Elaboration checks
   // ****************************************************************
   if (DENS_DEFAULT < DENS_MIN || DENS_DEFAULT > DENS_MAX) begin : g_bad_density
      $error("Default density constant must lie between 4 and 8.");
   end
   // The select field must be able to name every section.
   if ((1 << SELECT_W) < SECTIONS) begin : g_bad_select
      $error("Select field is too narrow for the section count.");
   end
   // The position field must hold the highest end bit at the largest density.
   if ((1 << POS_W) < ((1 << DENS_MAX) + 32'd129)) begin : g_bad_pos
      $error("Position field is too narrow for the largest density.");
   end
   for (genvar k = 0; k < SECTIONS; k++) begin : g_chk
      // Only 8K, 32K and 64K blocks carry protection bits.
      if (SECT_TYPE[k] < TYPE_SMALL || SECT_TYPE[k] > TYPE_LARGE) begin : g_bad_type
         $error("Section type code must name an 8K, 32K or 64K block.");
      end
   end

   // ****************************************************************
   // State
   // ****************************************************************
   logic [3:0] dens_q, dens_d;
   logic [SELECT_W-1:0] sel_q, sel_d;
   logic refused_q, refused_d;
   logic ack_q, ack_d;
   logic [DAT_W-1:0] dat_q, dat_d;

   // ****************************************************************
   // Bus decode
   // ****************************************************************
   wire req = WB_CYC_I && WB_STB_I && !ack_q;
   wire wr = req && WB_WE_I;
   wire hit_ctrl = (WB_ADR_I == OFS_CTRL);
   wire hit_select = (WB_ADR_I == OFS_SELECT);
   wire hit_entry = (WB_ADR_I == OFS_ENTRY);
   wire hit_pos = (WB_ADR_I == OFS_POS);
   wire hit_status = (WB_ADR_I == OFS_STATUS);
   wire hit_blocks = (WB_ADR_I == OFS_BLOCKS);
   wire hit_base = (WB_ADR_I == OFS_BASE);
   wire [3:0] wr_dens = WB_DAT_I[CTRL_DENS_LSB +: CTRL_DENS_W];
   wire [SELECT_W-1:0] wr_sel = WB_DAT_I[SELECT_W-1:0];
   wire dens_in_range = (wr_dens >= DENS_MIN) && (wr_dens <= DENS_MAX);
   wire sel_in_range = (wr_sel < SELECT_W'(SECTIONS));
   wire wr_ctrl = wr && hit_ctrl && WB_SEL_I[0];
   wire wr_select = wr && hit_select && WB_SEL_I[0];

   // ****************************************************************
   // Per-section entries and their decoded meaning
   // ****************************************************************
   // Index 0 is section one at address zero; only blocks with protection
   // bits appear, so the uniform small sectors have no entry at all.
   logic [7:0] ent_type [SECTIONS];
   logic [7:0] ent_count [SECTIONS];
   logic [POS_W-1:0] start_pos [SECTIONS];
   logic [POS_W-1:0] end_pos [SECTIONS];
   logic [POS_W-1:0] blocks [SECTIONS];
   logic [BASE_W-1:0] base [SECTIONS+1];
   logic [SECTIONS-1:0] sect_ok;

   assign base[0] = '0;

   for (genvar i = 0; i < SECTIONS; i++) begin : g_sect
      logic start_neg, end_neg;
      logic [POS_W-1:0] span, expect_bits;
      logic [23:0] blk_size;
      logic type_legal, order_ok;

      // Fixed order: type, count, start, end; large count byte is m.
      assign ent_type[i] = SECT_TYPE[i];
      assign ent_count[i] = (SECT_TYPE[i] == TYPE_LARGE) ? {4'h0, dens_q} : SECT_COUNT[i];

      protect_loc_decode u_start (
         .adder(SECT_START[i]),
         .density(dens_q),
         .is_start(1'b1),
         .pos(start_pos[i]),
         .below_zero(start_neg)
      );
      protect_loc_decode u_end (
         .adder(SECT_END[i]),
         .density(dens_q),
         .is_start(1'b0),
         .pos(end_pos[i]),
         .below_zero(end_neg)
      );

      // Large blocks number 2^m-2, the others 2^n.
      assign blocks[i] = (ent_type[i] == TYPE_LARGE) ?
                         POS_W'((POS_W'(1) << ent_count[i][3:0]) - POS_W'(2)) :
                         POS_W'(POS_W'(1) << ent_count[i][3:0]);
      // Small blocks own a read-lock and a write-lock bit each.
      assign expect_bits = (ent_type[i] == TYPE_SMALL) ?
                           POS_W'(blocks[i] << 1) : blocks[i];
      // One bit per position, start to end inclusive.
      assign span = POS_W'(end_pos[i] - start_pos[i] + POS_W'(1));
      assign order_ok = !start_neg && !end_neg && (end_pos[i] >= start_pos[i]);
      assign type_legal = (ent_type[i] >= TYPE_MIN) && (ent_type[i] <= TYPE_LARGE);
      assign sect_ok[i] = type_legal && order_ok && (span == expect_bits);

      assign blk_size = (ent_type[i] == TYPE_SMALL) ? SIZE_SMALL :
                        (ent_type[i] == TYPE_MID) ? SIZE_MID :
                        (ent_type[i] == TYPE_LARGE) ? SIZE_LARGE : 24'h000000;
      // Running base address, as a host would derive it.
      assign base[i+1] = BASE_W'(base[i] + BASE_W'(blk_size * blocks[i]));
   end

   // ****************************************************************
   // Selected section and read data
   // ****************************************************************
   wire [7:0] s_type = ent_type[sel_q];
   wire [7:0] s_count = ent_count[sel_q];
   wire [7:0] s_start = SECT_START[sel_q];
   wire [7:0] s_end = SECT_END[sel_q];
   wire [POS_W-1:0] s_start_pos = start_pos[sel_q];
   wire [POS_W-1:0] s_end_pos = end_pos[sel_q];
   wire s_ok = sect_ok[sel_q];
   wire all_ok = &sect_ok;

   wire [DAT_W-1:0] rd_entry = {s_end, s_start, s_count, s_type};
   wire [DAT_W-1:0] rd_pos = {s_ok, 5'h00, s_end_pos, 6'h00, s_start_pos};
   wire [DAT_W-1:0] rd_ctrl = DAT_W'(dens_q);
   wire [DAT_W-1:0] rd_select = DAT_W'(sel_q);
   wire [DAT_W-1:0] rd_status = DAT_W'({s_ok, refused_q, all_ok});
   wire [DAT_W-1:0] rd_blocks = DAT_W'(blocks[sel_q]);
   wire [DAT_W-1:0] rd_base = DAT_W'(base[sel_q]);

   // Unmapped addresses answer normally with zero data.
   wire [DAT_W-1:0] rd_mux = hit_ctrl ? rd_ctrl :
                             hit_select ? rd_select :
                             hit_entry ? rd_entry :
                             hit_pos ? rd_pos :
                             hit_status ? rd_status :
                             hit_blocks ? rd_blocks :
                             hit_base ? rd_base : '0;

   // ****************************************************************
   // Next-state logic
   // ****************************************************************
   always_comb begin
      dens_d = dens_q;
      sel_d = sel_q;
      refused_d = refused_q;
      ack_d = req;
      dat_d = (req && !WB_WE_I) ? rd_mux : dat_q;
      // A density outside 4..8 is refused and the old value kept.
      if (wr_ctrl) begin
         if (dens_in_range) begin
            dens_d = wr_dens;
            refused_d = 1'b0;
         end else begin
            refused_d = 1'b1;
         end
      end
      if (wr_select) begin
         if (sel_in_range) begin
            sel_d = wr_sel;
         end else begin
            refused_d = 1'b1;
         end
      end
   end

   // ****************************************************************
   // Registers
   // ****************************************************************
   // Outside reset, every register holds its value while the clock enable is low.
   always_ff @(posedge MCLK) begin
      if (!RST_N) begin
         dens_q <= DENS_DEFAULT;
      end else if (CE) begin
         dens_q <= dens_d;
      end
   end

   always_ff @(posedge MCLK) begin
      if (!RST_N) begin
         sel_q <= SELECT_RESET;
      end else if (CE) begin
         sel_q <= sel_d;
      end
   end

   always_ff @(posedge MCLK) begin
      if (!RST_N) begin
         refused_q <= 1'b0;
      end else if (CE) begin
         refused_q <= refused_d;
      end
   end

   // The acknowledge lasts one clock-enabled cycle because a request is not taken while it stands.
   always_ff @(posedge MCLK) begin
      if (!RST_N) begin
         ack_q <= 1'b0;
      end else if (CE) begin
         ack_q <= ack_d;
      end
   end

   always_ff @(posedge MCLK) begin
      if (!RST_N) begin
         dat_q <= '0;
      end else if (CE) begin
         dat_q <= dat_d;
      end
   end

   assign WB_ACK_O = ack_q;
   assign WB_DAT_O = dat_q;
endmodule
`default_nettype wire

// *** dv/fpm_assertions.sv ***
`timescale 1ns/1ps
`default_nettype none
module fpm_assertions import flash_protection_map_pkg::*; (
   input wire logic MCLK,
   input wire logic RST_N,
   input wire logic CE,
   input wire logic WB_CYC_I,
   input wire logic WB_STB_I,
   input wire logic WB_WE_I,
   input wire logic [flash_protection_map_pkg::ADR_W-1:0] WB_ADR_I,
   input wire logic [flash_protection_map_pkg::DAT_W-1:0] WB_DAT_O,
   input wire logic WB_ACK_O
);
   default clocking @(posedge MCLK); endclocking
   default disable iff (!RST_N);
   sequence req_s;
      WB_CYC_I && WB_STB_I && !WB_ACK_O && CE;
   endsequence
   sequence rd_s(logic [7:0] a);
      req_s ##0 (!WB_WE_I && WB_ADR_I == a);
   endsequence
   ack_follows_req_a: assert property (req_s |=> WB_ACK_O) else $error("ack missing");
   ack_one_pulse_a: assert property (WB_ACK_O && CE |=> !WB_ACK_O) else $error("ack too long");
   ack_has_cause_a: assert property ($rose(WB_ACK_O) |-> $past(WB_CYC_I && WB_STB_I)) else $error("stray ack");
   rdata_holds_a: assert property (!(WB_CYC_I && WB_STB_I && !WB_ACK_O && CE && !WB_WE_I) |=> $stable(WB_DAT_O))
      else $error("read data moved");
   unmapped_zero_a: assert property (req_s ##0 (!WB_WE_I && WB_ADR_I > OFS_BASE) |=> WB_DAT_O == 32'h0)
      else $error("unmapped read not zero");
   density_range_a: assert property (rd_s(OFS_CTRL) |=> WB_DAT_O[3:0] inside {[DENS_MIN:DENS_MAX]})
      else $error("density out of range");
   entry_type_a: assert property (rd_s(OFS_ENTRY) |=> WB_DAT_O[7:0] inside {[TYPE_SMALL:TYPE_LARGE]})
      else $error("bad sector type");
   pos_order_a: assert property (rd_s(OFS_POS) |=> WB_DAT_O[31] && WB_DAT_O[25:16] >= WB_DAT_O[9:0])
      else $error("end below start");
   all_consistent_a: assert property (rd_s(OFS_STATUS) |=> WB_DAT_O[0]) else $error("map inconsistent");
endmodule
bind flash_protection_map_decoder fpm_assertions fpm_assertions_inst (.MCLK(MCLK), .RST_N(RST_N), .CE(CE),
   .WB_CYC_I(WB_CYC_I), .WB_STB_I(WB_STB_I), .WB_WE_I(WB_WE_I), .WB_ADR_I(WB_ADR_I),
   .WB_DAT_O(WB_DAT_O), .WB_ACK_O(WB_ACK_O));
`default_nettype wire

// *** dv/host_bus_master.sv ***
`timescale 1ns/1ps
`default_nettype none
module host_bus_master (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic start,
   input wire logic we,
   input wire logic [7:0] adr,
   input wire logic [31:0] wdat,
   input wire logic ack,
   output logic cyc,
   output logic we_o,
   output logic [7:0] adr_o,
   output logic [31:0] dat_o,
   output logic done
);
   initial begin
      cyc = 1'b0;
      we_o = 1'b0;
      adr_o = 8'h00;
      dat_o = 32'h0;
      done = 1'b0;
   end
   always @(posedge clk) begin
      done <= 1'b0;
      if (!rst_n) begin
         cyc <= 1'b0;
      end else if (cyc && ack) begin
         // Released address and data lines show inverted values so nothing can lean on stale ones.
         cyc <= 1'b0;
         adr_o <= ~adr_o;
         dat_o <= ~dat_o;
         done <= 1'b1;
      end else if (start && !cyc && !done) begin
         cyc <= 1'b1;
         we_o <= we;
         adr_o <= adr;
         dat_o <= wdat;
      end
   end
endmodule
`default_nettype wire

// *** dv/tb.sv ***
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin checked++; if ((g) !== (e)) begin errors++; $display("MISMATCH %s exp %h got %h", n, e, g); end end
module tb;
   import flash_protection_map_pkg::*;
   logic MCLK, RST_N, CE, start, we_r, cyc, wen, ack, done;
   logic [7:0] adr_r, adr_w;
   logic [31:0] wd_r, dat_w, rdat, r;
   logic [3:0] sel_r;
   int m, cur, refused, errors, checked, cycles, seed;
   localparam logic [7:0] TY [5] = '{8'h02, 8'h03, 8'h04, 8'h03, 8'h02};
   localparam logic [7:0] SB [5] = '{8'hff, 8'hfd, 8'h00, 8'hfe, 8'h07};
   localparam logic [7:0] EB [5] = '{8'h06, 8'hfd, 8'hfc, 8'hfe, 8'h0e};
   localparam int SZ [5] = '{'h2000, 'h8000, 'h10000, 'h8000, 'h2000};
   host_bus_master host_bus_master_inst (.clk(MCLK), .rst_n(RST_N), .start(start), .we(we_r), .adr(adr_r),
      .wdat(wd_r), .ack(ack), .cyc(cyc), .we_o(wen), .adr_o(adr_w), .dat_o(dat_w), .done(done));
   flash_protection_map_decoder flash_protection_map_decoder_inst (.MCLK(MCLK), .RST_N(RST_N), .CE(CE),
      .WB_CYC_I(cyc), .WB_STB_I(cyc), .WB_WE_I(wen), .WB_ADR_I(adr_w), .WB_SEL_I(sel_r), .WB_DAT_I(dat_w),
      .WB_DAT_O(rdat), .WB_ACK_O(ack));
   // ****************************************
   // Expected map
   // ****************************************
   function automatic logic [9:0] loc(logic [7:0] c, bit is_start);
      if (is_start && c == 8'h00) return 10'h000;
      return 10'((1 << m) + 1 + int'($signed(c)));
   endfunction
   function automatic int blocks(int s);
      return (s == 2) ? (1 << m) - 2 : (s == 0 || s == 4) ? 4 : 1;
   endfunction
   function automatic logic [31:0] exp_rd(logic [7:0] a);
      int base;
      logic [7:0] cnt;
      base = 0;
      for (int i = 0; i < cur; i++) base += SZ[i] * blocks(i);
      cnt = (cur == 2) ? 8'(m) : (TY[cur] == 8'h02) ? 8'h02 : 8'h00;
      case (a)
         OFS_CTRL: return 32'(m);
         OFS_SELECT: return 32'(cur);
         OFS_ENTRY: return {EB[cur], SB[cur], cnt, TY[cur]};
         OFS_POS: return {1'b1, 5'h00, loc(EB[cur], 0), 6'h00, loc(SB[cur], 1)};
         OFS_STATUS: return {29'h0, 1'b1, refused[0], 1'b1};
         OFS_BLOCKS: return 32'(blocks(cur));
         OFS_BASE: return 32'(base);
         default: return 32'h0;
      endcase
   endfunction
   task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
      start <= 1'b1;
      we_r <= w;
      adr_r <= a;
      wd_r <= d;
      sel_r <= s;
      @(posedge MCLK);
      start <= 1'b0;
      do @(negedge MCLK); while (!done);
      @(posedge MCLK);
   endtask
   task automatic rd(input logic [7:0] a);
      xfer(1'b0, a, 32'h0, 4'hf);
      `CHK("read", exp_rd(a), rdat)
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
      xfer(1'b1, a, d, s);
      if (s[0] && a == OFS_CTRL) begin
         if (d[3:0] >= DENS_MIN && d[3:0] <= DENS_MAX) begin
            m = d[3:0];
            refused = 0;
         end else refused = 1;
      end
      if (s[0] && a == OFS_SELECT) begin
         if (d[2:0] <= 3'h4) cur = d[2:0];
         else refused = 1;
      end
   endtask
   task automatic conclude();
      $display("checked %0d errors %0d", checked, errors);
      if (errors == 0 && checked > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   initial begin
      MCLK = 1'b0;
      forever #2.5 MCLK = ~MCLK;
   end
   always @(posedge MCLK) begin
      cycles <= cycles + 1;
      if (cycles == 30000) begin
         errors++;
         conclude();
      end
   end
   initial begin
      {CE, start, RST_N, we_r, adr_r, wd_r, sel_r} = {1'b1, 47'h0};
      {m, cur, refused, errors, checked, cycles, seed} = {32'd6, 32'd0, 32'd0, 32'd0, 32'd0, 32'd0, 32'd61};
      repeat (5) @(posedge MCLK);
      RST_N <= 1'b1;
      @(posedge MCLK);
      for (int a = 0; a < 8; a++) rd(8'(a * 4));
      $display("reset test done");
      for (int d = 4; d <= 8; d++) begin
         wr(OFS_CTRL, 32'(d), 4'h1);
         for (int s = 0; s < 5; s++) begin
            wr(OFS_SELECT, 32'(s), 4'h1);
            for (int a = 2; a <= 6; a++) rd(8'(a * 4));
         end
      end
      $display("map test done");
      wr(OFS_CTRL, 32'h3, 4'h1);
      wr(OFS_SELECT, 32'h5, 4'h1);
      wr(OFS_CTRL, 32'h4, 4'he);
      for (int a = 0; a < 5; a++) rd(8'(a * 4));
      wr(OFS_CTRL, 32'h9, 4'h1);
      rd(OFS_STATUS);
      $display("refusal test done");
      repeat (300) begin
         r = $random(seed);
         CE <= r[8] | r[9];
         @(posedge MCLK);
         CE <= 1'b1;
         if (r[10]) wr({r[7:2], 2'b00} | 8'h08, $random(seed), 4'hf);
         else if (r[11]) wr(OFS_SELECT, 32'(r[14:12]), {3'h0, r[15]});
         else if (r[16]) wr(OFS_CTRL, 32'(r[20:17]), {3'h0, r[21]});
         else rd({r[7:2], 2'b00});
      end
      CE <= 1'b1;
      RST_N <= 1'b0;
      repeat (2) @(posedge MCLK);
      RST_N <= 1'b1;
      {m, cur, refused} = {32'd6, 32'd0, 32'd0};
      @(posedge MCLK);
      for (int a = 0; a < 7; a++) rd(8'(a * 4));
      $display("random and second reset test done");
      conclude();
   end
endmodule
`default_nettype wire
